//--- wdt_timer.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

// watchdog / interval timer with apb registers
// everything runs on clk_sys; the prescaler hands back a one-cycle
// tick, so the count never needs a second clock domain
// limitation: the reset pulse only leaves through wdt_reset_out;
// nothing in here resets the rest of the chip, that is wiring
// trade-off: read data is latched in the setup cycle, so every
// access answers with no wait state, but a count read shows the
// value one cycle older than the access edge
// the interrupt status and mask words go beyond the bare timer;
// they let software tell an interval wrap from a watchdog wrap
// only the low byte of each word is live; upper lanes read zero
// an unmapped address answers with pslverr and zero data, and a
// write to it changes nothing
// the flag clear needs a read that returned it set, then a control
// write with the flag bit low; any other control write disarms it
module wdt_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wdt_reset_out
);

    // byte addresses built from the register indices
    // the printed offsets are not word aligned, so each one is an
    // index and the bus address is four times it; the top ten bits
    // are zero, which keeps the block in the low part of the map
    localparam logic [31:0] ADDR_CSR =
        {10'h000, `WDT_IDX_CTRL_STATUS, 2'h0};
    localparam logic [31:0] ADDR_CNT =
        {10'h000, `WDT_IDX_COUNT, 2'h0};
    localparam logic [31:0] ADDR_IST =
        {10'h000, `WDT_IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] ADDR_IMSK =
        {10'h000, `WDT_IDX_IRQ_MASK, 2'h0};

    // address decode, used in setup and access phases
    function automatic wdt_pkg::wdt_regsel_type decode(
        input logic [31:0] addr);
        wdt_pkg::wdt_regsel_type s;
        // anything not matched exactly stays unmapped, which
        // also rejects byte offsets inside a word
        s = wdt_pkg::WDT_SEL_NONE;
        // exact compares: a partial decode would alias the map
        if (addr == ADDR_CSR) begin
            s = wdt_pkg::WDT_SEL_CSR;
        end else if (addr == ADDR_CNT) begin
            s = wdt_pkg::WDT_SEL_CNT;
        end else if (addr == ADDR_IST) begin
            s = wdt_pkg::WDT_SEL_IST;
        end else if (addr == ADDR_IMSK) begin
            s = wdt_pkg::WDT_SEL_IMSK;
        end
        return s;
    endfunction

    // assemble the control/status byte as software sees it
    function automatic logic [7:0] csr_image(
        input wdt_pkg::wdt_state_type st);
        logic [7:0] v;
        // unused bits 4 and 3 always read as one
        v = `WDT_CSR_FIXED_ONES;
        // live fields overlay the fixed pattern
        v[`WDT_BIT_WRAP_FLAG] = st.wrap_flag;
        v[`WDT_BIT_MODE] = st.mode;
        v[`WDT_BIT_RUN] = st.run;
        v[`WDT_SEL_MSB:`WDT_SEL_LSB] = st.sel;
        return v;
    endfunction

    // all state lives in one struct: one process computes the next
    // copy, one register stores it, so no field can get a second
    // driver by accident
    wdt_pkg::wdt_state_type cur_reg; // registered state
    wdt_pkg::wdt_state_type cur_next; // next state

    // run and select go out, the tick comes back on one bundle
    wdt_tick_if tick_bus (); // link to the prescaler

    // bus qualifiers and event wires, all combinational
    // none of these is stored; they are recomputed every cycle
    logic setup_phase; // first cycle of an apb transfer
    logic access_done; // access cycle that completes
    logic wr_done; // completing write
    logic rd_done; // completing read
    wdt_pkg::wdt_regsel_type acc_sel; // register of this access
    logic wrap_event; // counter steps from FF to 00
    logic [1:0] irq_set; // events feeding interrupt status

    // the prescaler follows the live control bits
    // run low also clears the divider, so a restart always waits a
    // full period before the first tick
    assign tick_bus.run = cur_reg.run;
    assign tick_bus.sel = cur_reg.sel;

    // prescaler instance
    // it shares clk_sys and rst, so the tick needs no synchroniser
    wdt_prescaler u_pre (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick_port(tick_bus.ctrl)
    );

    // apb phase qualifiers
    // pready is our own flop, so access_done is true for exactly
    // one edge per transfer
    always_comb begin
        // setup: select without enable
        setup_phase = psel && !penable;
        // completing edge: enable and our ready both high
        access_done = psel && penable && cur_reg.pready;
        // direction splits the completing edge into write and read
        wr_done = access_done && pwrite;
        rd_done = access_done && !pwrite;
        // address is held from setup to access, so one decode
        // serves both phases
        acc_sel = decode(paddr);
    end

    // counter wrap and event sources
    // a wrap needs a tick, so a software write of FF alone never
    // counts as one; the flag waits for the real step to 00
    always_comb begin
        // only a running counter can wrap
        wrap_event = cur_reg.run && tick_bus.tick &&
            (cur_reg.count == `WDT_COUNT_MAX);
        irq_set = 2'h0;
        // interval mode raises an interrupt event
        irq_set[`WDT_IRQ_BIT_INTERVAL] = wrap_event && !cur_reg.mode;
        // watchdog mode logs the reset it causes
        irq_set[`WDT_IRQ_BIT_WATCHDOG] = wrap_event && cur_reg.mode;
    end

    // next-state logic for the whole block
    always_comb begin
        cur_next = cur_reg;
        // pready drops after every access, zero wait otherwise
        // both are one-cycle pulses: a master that holds psel past
        // the access would otherwise see a second ready
        cur_next.pready = 1'b0;
        cur_next.pslverr = 1'b0;

        // setup cycle: capture read data and decode error
        // prdata then stands until the next setup, which keeps the
        // read mux off the access edge
        if (setup_phase) begin
            cur_next.pready = 1'b1;
            cur_next.pslverr = (acc_sel == wdt_pkg::WDT_SEL_NONE);
            unique case (acc_sel)
                wdt_pkg::WDT_SEL_CSR: begin
                    // control word with its fixed ones
                    cur_next.prdata = {24'h000000, csr_image(cur_reg)};
                end
                wdt_pkg::WDT_SEL_CNT: begin
                    // live count byte
                    cur_next.prdata = {24'h000000, cur_reg.count};
                end
                wdt_pkg::WDT_SEL_IST: begin
                    // sticky event bits
                    cur_next.prdata = {30'h0, cur_reg.irq_status};
                end
                wdt_pkg::WDT_SEL_IMSK: begin
                    // enable bits as written
                    cur_next.prdata = {30'h0, cur_reg.irq_mask};
                end
                wdt_pkg::WDT_SEL_NONE: begin
                    // unmapped reads return zero with the error
                    cur_next.prdata = 32'h00000000;
                end
            endcase
        end

        // a read that returned the flag set arms the clear
        // the test uses the data actually returned, so a wrap that
        // lands after the setup edge cannot be cleared unseen
        if (rd_done && acc_sel == wdt_pkg::WDT_SEL_CSR &&
            cur_reg.prdata[`WDT_BIT_WRAP_FLAG]) begin
            cur_next.clear_armed = 1'b1;
        end

        // register writes, taken on the completing access edge
        // bits 4 and 3 of the control word are not stored; they are
        // constants in the read image
        if (wr_done) begin
            unique case (acc_sel)
                wdt_pkg::WDT_SEL_CSR: begin
                    // mode, run and select are plain stores
                    cur_next.mode = pwdata[`WDT_BIT_MODE];
                    cur_next.run = pwdata[`WDT_BIT_RUN];
                    cur_next.sel =
                        pwdata[`WDT_SEL_MSB:`WDT_SEL_LSB];
                    // only a zero after the arming read clears;
                    // a one written here is ignored
                    if (!pwdata[`WDT_BIT_WRAP_FLAG] &&
                        cur_reg.clear_armed) begin
                        cur_next.wrap_flag = 1'b0;
                    end
                    // any control write uses up the arming read
                    cur_next.clear_armed = 1'b0;
                end
                wdt_pkg::WDT_SEL_CNT: begin
                    // a software write beats a same-cycle tick
                    cur_next.count = pwdata[7:0];
                end
                wdt_pkg::WDT_SEL_IST: begin
                    // write one to clear
                    cur_next.irq_status =
                        cur_reg.irq_status & ~pwdata[1:0];
                end
                wdt_pkg::WDT_SEL_IMSK: begin
                    // plain store; a one enables that status bit
                    cur_next.irq_mask = pwdata[1:0];
                end
                wdt_pkg::WDT_SEL_NONE: begin
                    // unmapped writes change nothing
                end
            endcase
        end

        // counting, unless software wrote the count this cycle
        // letting the write win means software reads back what it
        // wrote; the lost tick is at most one step
        if (cur_reg.run && tick_bus.tick &&
            !(wr_done && acc_sel == wdt_pkg::WDT_SEL_CNT)) begin
            // one step per tick, wrapping FF to 00
            cur_next.count = cur_reg.count + 8'h01;
        end

        // a halted counter sits at zero, whatever software wrote
        // uses the next run bit, so the write that stops the timer
        // clears the count on the same edge
        if (!cur_next.run) begin
            cur_next.count = `WDT_RST_COUNT;
        end

        // set beats a simultaneous clear for the wrap flag
        // it sets in watchdog mode too, so software can see the
        // wrap that caused a reset
        if (wrap_event) begin
            cur_next.wrap_flag = 1'b1;
        end

        // sticky interrupt status, set wins over clear
        // an event and a clear on one edge leave the bit set, so no
        // event can be lost to a late clear
        cur_next.irq_status = cur_next.irq_status | irq_set;

        // watchdog reset pulse of fixed length
        // a new wrap during the pulse restarts it, so the pulse is
        // never cut short by a second overflow
        if (irq_set[`WDT_IRQ_BIT_WATCHDOG]) begin
            cur_next.reset_cnt = `WDT_RESET_PULSE_CYCLES;
        end else if (cur_reg.reset_cnt != 5'h00) begin
            cur_next.reset_cnt = cur_reg.reset_cnt - 5'h01;
        end
        cur_next.reset_out = (cur_next.reset_cnt != 5'h00);

        // level interrupt, registered so the port comes from a flop
        // built from the next status and mask, so irq rises on the
        // same edge as the status bit and a mask write acts at once
        cur_next.irq = |(cur_next.irq_status & cur_next.irq_mask);
    end

    // state register; every field takes a constant at reset
    // the named fields are repeated so a new reset value in the
    // configuration header reaches them without a code edit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // clear all, then the fields with named reset values
            cur_reg <= '0;
            cur_reg.count <= `WDT_RST_COUNT;
            cur_reg.sel <= `WDT_RST_SEL;
            cur_reg.irq_mask <= `WDT_RST_MASK;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ports straight from flip-flops
    // no output passes through logic, so nothing glitches at the pins
    assign prdata = cur_reg.prdata;
    assign pready = cur_reg.pready;
    assign pslverr = cur_reg.pslverr;
    assign irq = cur_reg.irq;
    assign wdt_reset_out = cur_reg.reset_out;

endmodule

`default_nettype wire

//--- wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// register indices; byte address is four times the index
`define WDT_IDX_CTRL_STATUS 20'hFFF8C
`define WDT_IDX_COUNT 20'hFFF8D
`define WDT_IDX_IRQ_STATUS 20'hFFF8E
`define WDT_IDX_IRQ_MASK 20'hFFF8F

// control/status field positions
`define WDT_BIT_WRAP_FLAG 7
`define WDT_BIT_MODE 6
`define WDT_BIT_RUN 5
`define WDT_SEL_MSB 2
`define WDT_SEL_LSB 0
// bits 4 and 3 are unused and read as one
`define WDT_CSR_FIXED_ONES 8'h18

// interrupt status / mask field positions
`define WDT_IRQ_BIT_INTERVAL 0
`define WDT_IRQ_BIT_WATCHDOG 1

// reset values
`define WDT_RST_COUNT 8'h00
`define WDT_RST_SEL 3'h0
`define WDT_RST_MASK 2'h0

// counter wrap point
`define WDT_COUNT_MAX 8'hFF

// length of the watchdog reset pulse, in clk_sys cycles
`define WDT_RESET_PULSE_CYCLES 5'h10

`endif

//--- wdt_pkg.sv
package wdt_pkg;

    // which register an address hits
    typedef enum logic [2:0] {
        WDT_SEL_NONE,
        WDT_SEL_CSR,
        WDT_SEL_CNT,
        WDT_SEL_IST,
        WDT_SEL_IMSK
    } wdt_regsel_type;

    // whole state of the control module
    typedef struct packed {
        logic [7:0] count;
        logic wrap_flag;
        logic mode;
        logic run;
        logic [2:0] sel;
        logic clear_armed;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic irq;
        logic reset_out;
        logic [4:0] reset_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } wdt_state_type;

    // whole state of the prescaler
    typedef struct packed {
        logic [11:0] div_cnt;
        logic tick;
    } wdt_pre_state_type;

endpackage

//--- wdt_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

// carries run/select to the prescaler and the tick back
interface wdt_tick_if;
    logic run;
    logic [2:0] sel;
    logic tick;

    modport ctrl (output run, output sel, input tick);
    modport pre (input run, input sel, output tick);
endinterface

`default_nettype wire

//--- wdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

// divides clk_sys into a one-cycle tick at the selected rate
module wdt_prescaler (
    input wire logic clk_sys,
    input wire logic rst,
    wdt_tick_if.pre tick_port
);

    // mask of low divider bits for each select code
    function automatic logic [11:0] div_mask(input logic [2:0] sel);
        logic [11:0] m;
        m = 12'h000;
        unique case (sel)
            3'h0: m = 12'h001; // phi/2
            3'h1: m = 12'h01F; // phi/32
            3'h2: m = 12'h03F; // phi/64
            3'h3: m = 12'h07F; // phi/128
            3'h4: m = 12'h0FF; // phi/256
            3'h5: m = 12'h1FF; // phi/512
            3'h6: m = 12'h7FF; // phi/2048
            3'h7: m = 12'hFFF; // phi/4096
        endcase
        return m;
    endfunction

    wdt_pkg::wdt_pre_state_type cur_reg; // registered state
    wdt_pkg::wdt_pre_state_type cur_next; // next state

    // divider runs only while enabled, so the first period is full
    always_comb begin
        cur_next = cur_reg;
        cur_next.tick = 1'b0;
        if (!tick_port.run) begin
            cur_next.div_cnt = 12'h000;
        end else begin
            cur_next.div_cnt = cur_reg.div_cnt + 12'h001;
            // tick when all selected low bits are set
            if ((cur_reg.div_cnt & div_mask(tick_port.sel)) ==
                div_mask(tick_port.sel)) begin
                cur_next.tick = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign tick_port.tick = cur_reg.tick;

endmodule

`default_nettype wire

//--- wdt_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

// port-level checks on bus answers and timer outputs
module wdt_timer_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic wdt_reset_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic setup = psel && !penable; // setup cycle on the bus
    wire logic acc = psel && penable && pready; // completing access
    wire logic csr_hit = paddr == {10'h0, `WDT_IDX_CTRL_STATUS, 2'h0};
    wire logic cnt_hit = paddr == {10'h0, `WDT_IDX_COUNT, 2'h0};
    wire logic msk_hit = paddr == {10'h0, `WDT_IDX_IRQ_MASK, 2'h0};
    // all four words share one 16-byte row
    wire logic mapped = paddr[31:4] == 28'h003FFE3 && paddr[1:0] == 2'h0;
    logic run_q; // run enable as last written
    logic [7:0] hi_cnt; // cycles the reset output has stood high

    // length of the current reset pulse, saturating
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hi_cnt <= 8'h00;
        end else if (!wdt_reset_out) begin
            hi_cnt <= 8'h00;
        end else if (hi_cnt != 8'hFF) begin
            hi_cnt <= hi_cnt + 8'h01;
        end
    end

    // track run so halted reads can be judged
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else if (acc && pwrite && csr_hit) begin
            run_q <= pwdata[`WDT_BIT_RUN];
        end
    end

    property p_zero_wait;
        setup |=> pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("late ready");
    property p_no_stray;
        !setup |=> !pready;
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray ready");
    property p_err_decode;
        setup |=> (pslverr == !$past(mapped));
    endproperty
    a_err_decode: assert property (p_err_decode) else $error("bad decode");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("bad error data");
    property p_csr_read;
        acc && !pwrite && csr_hit |->
            prdata[31:8] == 24'h0 && prdata[4:3] == 2'h3;
    endproperty
    a_csr_read: assert property (p_csr_read) else $error("csr fixed bits");
    // two cycles of margin: read data is latched in the setup cycle, one cycle before the access
    property p_halt_zero;
        acc && !pwrite && cnt_hit && !run_q && !$past(run_q)
            && !$past(run_q, 2) |-> prdata[7:0] == 8'h00;
    endproperty
    a_halt_zero: assert property (p_halt_zero)
        else $error("count moved");
    property p_pulse;
        $rose(wdt_reset_out) |-> wdt_reset_out [*8];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("short reset pulse");
    // a pulse that ends must have stood its full length
    property p_pulse_len;
        $fell(wdt_reset_out) |->
            hi_cnt >= {3'h0, `WDT_RESET_PULSE_CYCLES};
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length");
    property p_mask_off;
        acc && pwrite && msk_hit && pwdata[1:0] == 2'h0 |=> ##[0:1] !irq;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("irq not masked");
    c_irq: cover property ($rose(irq));
    c_reset: cover property ($rose(wdt_reset_out));
    c_err: cover property (pslverr);
endmodule

bind wdt_timer wdt_timer_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .wdt_reset_out(wdt_reset_out));

`default_nettype wire

//--- wdt_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

// self-checking bench for the watchdog / interval timer
module wdt_timer_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq, wdt_reset_out;
    logic [31:0] rd; // last read data
    logic [31:0] er; // last error flag
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    localparam logic [31:0] AC = {10'h0, `WDT_IDX_CTRL_STATUS, 2'h0};
    localparam logic [31:0] AN = {10'h0, `WDT_IDX_COUNT, 2'h0};
    localparam logic [31:0] AI = {10'h0, `WDT_IDX_IRQ_STATUS, 2'h0};
    localparam logic [31:0] AM = {10'h0, `WDT_IDX_IRQ_MASK, 2'h0};
    // divider of each select code
    localparam int PER [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

    always #4 clk_sys = ~clk_sys;

    wdt_timer uut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .wdt_reset_out(wdt_reset_out));

    // hang guard, well past the divider sweep
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one apb transfer; ready is sampled at the rising edges of the
    // access phase, and the request stands until it is seen high
    task automatic apb(input logic w, input logic [31:0] a, input int d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        er = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_is(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 0);
        chk(rd, exp);
    endtask

    task automatic t_reset();
        rd_is(AC, 32'h18);
        rd_is(AN, 32'h0);
        rd_is(AI, 32'h0);
        rd_is(AM, 32'h0);
        apb(1'b1, AN, 32'h55);
        rd_is(AN, 32'h0);
    endtask

    // sample at three and a half periods: off-by-one slack either way, late side only at phi/2
    task automatic t_rates();
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, AC, 32'h20 | s);
            repeat (PER[s] * 7 / 2 - 1) @(posedge clk_sys);
            rd_is(AN, 32'h3);
            apb(1'b1, AC, 32'h0);
            rd_is(AN, 32'h0);
        end
    endtask

    task automatic t_write();
        apb(1'b1, AC, 32'h27);
        apb(1'b1, AN, 32'hFD);
        rd_is(AN, 32'hFD);
        apb(1'b1, AC, 32'h0);
    endtask

    task automatic t_wrap();
        apb(1'b1, AM, 32'h1);
        apb(1'b1, AC, 32'h20);
        apb(1'b1, AN, 32'hFE);
        repeat (8) @(posedge clk_sys);
        rd_is(AC, 32'hB8);
        rd_is(AI, 32'h1);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, wdt_reset_out}, 32'h0);
        apb(1'b1, AC, 32'hA0);
        apb(1'b1, AC, 32'h20);
        rd_is(AC, 32'hB8);
        apb(1'b1, AC, 32'h20);
        rd_is(AC, 32'h38);
        apb(1'b1, AC, 32'hA0);
        rd_is(AC, 32'h38);
        apb(1'b1, AM, 32'h0);
        repeat (3) @(negedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, AI, 32'h3);
        rd_is(AI, 32'h0);
        apb(1'b1, AC, 32'h0);
    endtask

    task automatic t_dog();
        int n;
        apb(1'b1, AM, 32'h2);
        apb(1'b1, AC, 32'h60);
        apb(1'b1, AN, 32'hFE);
        for (n = 0; n < 20 && wdt_reset_out !== 1'b1; n++)
            @(negedge clk_sys);
        chk({31'h0, wdt_reset_out}, 32'h1);
        rd_is(AI, 32'h2);
        chk({31'h0, irq}, 32'h1);
        rd_is(AC, 32'hF8);
        apb(1'b1, AC, 32'h0);
        rd_is(AC, 32'h18);
        apb(1'b1, AI, 32'h3);
    endtask

    // unmapped words answer with an error and zero data
    task automatic t_bad();
        apb(1'b0, 32'h0, 0);
        chk(er | rd, 32'h1);
        apb(1'b1, 32'h003FFE40, 32'hFF);
        chk(er, 32'h1);
        rd_is(AC, 32'h18);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_rates();
        t_write();
        t_wrap();
        t_dog();
        t_bad();
        conclude();
    end
endmodule

`default_nettype wire
